// File: verilog/tcc_pkg.sv
package tcc_pkg;

   // register word offsets (byte addresses, one aligned word each)
   localparam int NUM_CMP = 3;
   localparam logic [2:0][7:0] OFS_CMP_LO = {8'h10, 8'h08, 8'h00};
   localparam logic [2:0][7:0] OFS_CMP_HI = {8'h14, 8'h0c, 8'h04};
   localparam logic [7:0] OFS_CAP_LO = 8'h18;
   localparam logic [7:0] OFS_CAP_HI = 8'h1c;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_FLAGS = 8'h24;
   localparam logic [7:0] OFS_CTRL = 8'h28;
   localparam logic [7:0] OFS_FORCE = 8'h2c;

   // bit positions shared by mask, flags, vector acknowledge and requests
   localparam int BIT_OVF = 0;
   localparam int BIT_MATCH_A = 1;
   localparam int BIT_CAP = 5;
   localparam logic [7:0] IRQ_BITS = 8'h2f;

   // control register fields
   localparam int CTRL_WIDTH = 4;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h0;

   localparam logic [15:0] RESET16 = 16'h0000;
   localparam logic [7:0] RESET8 = 8'h00;
   localparam logic [31:0] ZERO32 = 32'h00000000;
   localparam logic [2:0] FORCE_BITS = 3'h7;

   // waveform modes that matter here
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
   localparam logic [3:0] MODE_PFC_CAP = 4'h8;
   localparam logic [3:0] MODE_PC_CAP = 4'ha;
   localparam logic [3:0] MODE_CTC_CAP = 4'hc;
   localparam logic [3:0] MODE_FAST_CAP = 4'he;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // filter needs this many equal samples before its output follows
   localparam int FILTER_SAMPLES = 4;

   typedef struct packed {
      logic global_irq_enable;
      logic analog_capture_select;
      logic capture_noise_filter_enable;
      logic capture_edge_select;
   } tcc_ctrl_type;

   typedef struct packed {
      logic write;
      logic [7:0] addr;
   } tcc_bus_req_type;

   typedef enum {TCC_PHASE_IDLE, TCC_PHASE_WRITE, TCC_PHASE_READ} tcc_phase_type;

endpackage

// File: verilog/tcc_capture_filter.sv
`timescale 1ns/1ps
module tcc_capture_filter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic filter_enable,
   input wire logic raw_in,
   output logic filtered
);
   logic [tcc_pkg::FILTER_SAMPLES-1:0] samples;
   logic [tcc_pkg::FILTER_SAMPLES-1:0] next_samples;
   logic next_filtered;

   always_comb begin
      next_samples = {samples[tcc_pkg::FILTER_SAMPLES-2:0], raw_in};
      next_filtered = filtered;
      if (!filter_enable) begin
         next_filtered = raw_in;
      end else if (&samples) begin
         next_filtered = 1'b1;
      end else if (~|samples) begin
         next_filtered = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samples <= '0;
         filtered <= 1'b0;
      end else begin
         samples <= next_samples;
         filtered <= next_filtered;
      end
   end
endmodule

// File: verilog/tcc_compare_capture.sv
`timescale 1ns/1ps
// Function
// - three 16-bit compares matched against count
// - compare writes commit through shared high latch
// - capture reads return bytes of one value
// - capture event copies count into capture
// - capture register can serve as top
// - request needs mask, global enable, flag
// - mask bits 5,3,2,1,0; others read zero
// - capture flag on event, or top reached
// - match flag set two cycles after equality
// - forced strobe never sets match flag
// - vector execution clears its flag
// - writing one clears a flag
// - overflow flag follows counter's overflow point
// - flags at bits 5,3,2,1,0
// - edge select: zero falling, one rising
// - capture disabled while capture is top
// - filter waits four equal samples
// - count write blocks next tick's matches
module tcc_compare_capture (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   input wire logic [15:0] COUNT,
   input wire logic TIMER_TICK,
   input wire logic COUNT_WRITE,
   input wire logic OVERFLOW_EVENT,
   input wire logic [3:0] WAVE_MODE,
   input wire logic CAPTURE_PIN,
   input wire logic COMPARATOR_OUT,
   input wire logic [7:0] VECTOR_ACK,
   output logic [2:0] COMPARE_EVENT,
   output logic [7:0] IRQ_REQUEST,
   output logic [15:0] CAPTURE_TOP_VALUE,
   output logic CAPTURE_IS_TOP
);
   tcc_pkg::tcc_phase_type phase, next_phase;
   tcc_pkg::tcc_bus_req_type req, next_req;
   tcc_pkg::tcc_ctrl_type ctrl, next_ctrl;
   logic [31:0] next_hrdata;
   logic [15:0] cmp [tcc_pkg::NUM_CMP];
   logic [15:0] next_cmp [tcc_pkg::NUM_CMP];
   logic [15:0] capture_value, next_capture_value;
   logic [7:0] temp, next_temp;
   logic [7:0] mask, next_mask;
   logic [7:0] flags, next_flags;
   logic [7:0] flag_set, flag_clr;
   logic blocked, next_blocked;
   logic [2:0] match_pulse, next_match_pulse;
   logic [2:0] force_pulse, next_force_pulse;
   logic [2:0] next_compare_event;
   logic [2:0] equal;
   logic pin_prev, next_pin_prev;
   logic filtered, cap_src, capture_event, top_reached, non_pwm;
   logic addr_valid, wr_data;
   localparam int BIT_A = tcc_pkg::BIT_MATCH_A;

   assign addr_valid = HSEL && HREADY && (HTRANS == tcc_pkg::HTRANS_NONSEQ);
   assign wr_data = (phase == tcc_pkg::TCC_PHASE_WRITE) && req.write;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // capture as top in the four capture-top modes
   assign CAPTURE_IS_TOP = (WAVE_MODE == tcc_pkg::MODE_PFC_CAP) ||
      (WAVE_MODE == tcc_pkg::MODE_PC_CAP) || (WAVE_MODE == tcc_pkg::MODE_CTC_CAP) ||
      (WAVE_MODE == tcc_pkg::MODE_FAST_CAP);
   assign CAPTURE_TOP_VALUE = capture_value;
   assign non_pwm = (WAVE_MODE == tcc_pkg::MODE_NORMAL) ||
      (WAVE_MODE == tcc_pkg::MODE_CTC_CMPA) || (WAVE_MODE == tcc_pkg::MODE_CTC_CAP);

   tcc_capture_filter u_filter (
      .clk(MCLK),
      .rst_n(NRST),
      .filter_enable(ctrl.capture_noise_filter_enable),
      .raw_in(CAPTURE_PIN),
      .filtered(filtered)
   );

   // the comparator path bypasses the pin filter
   assign cap_src = ctrl.analog_capture_select ? COMPARATOR_OUT : filtered;
   assign capture_event = !CAPTURE_IS_TOP && (ctrl.capture_edge_select ?
      (cap_src && !pin_prev) : (!cap_src && pin_prev));
   assign top_reached = CAPTURE_IS_TOP && TIMER_TICK && (COUNT == capture_value);

   genvar ch;
   generate
      for (ch = 0; ch < tcc_pkg::NUM_CMP; ch++) begin : g_eq
         assign equal[ch] = (COUNT == cmp[ch]);
      end
   endgenerate

   assign IRQ_REQUEST = mask & flags & {8{ctrl.global_irq_enable}};

   // bus side: address phase captured, reads answered one cycle later
   always_comb begin
      next_phase = tcc_pkg::TCC_PHASE_IDLE;
      next_req = req;
      next_hrdata = tcc_pkg::ZERO32;
      next_temp = temp;
      next_mask = mask;
      next_ctrl = ctrl;
      next_force_pulse = '0;
      next_capture_value = capture_value;
      flag_clr = VECTOR_ACK & tcc_pkg::IRQ_BITS;
      for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
         next_cmp[i] = cmp[i];
      end
      if (wr_data) begin
         for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
            if (req.addr == tcc_pkg::OFS_CMP_LO[i]) begin
               next_cmp[i] = {temp, HWDATA[7:0]};
            end
         end
         if (req.addr == tcc_pkg::OFS_CAP_LO) begin
            next_capture_value = {temp, HWDATA[7:0]};
         end else if ((req.addr == tcc_pkg::OFS_CAP_HI) || (req.addr == tcc_pkg::OFS_CMP_HI[0]) ||
                      (req.addr == tcc_pkg::OFS_CMP_HI[1]) ||
                      (req.addr == tcc_pkg::OFS_CMP_HI[2])) begin
            next_temp = HWDATA[7:0];
         end else if (req.addr == tcc_pkg::OFS_MASK) begin
            next_mask = HWDATA[7:0] & tcc_pkg::IRQ_BITS;
         end else if (req.addr == tcc_pkg::OFS_FLAGS) begin
            flag_clr = flag_clr | (HWDATA[7:0] & tcc_pkg::IRQ_BITS);
         end else if (req.addr == tcc_pkg::OFS_CTRL) begin
            next_ctrl = HWDATA[tcc_pkg::CTRL_WIDTH-1:0];
         end else if (req.addr == tcc_pkg::OFS_FORCE) begin
            next_force_pulse = HWDATA[2:0] & tcc_pkg::FORCE_BITS & {3{non_pwm}};
         end
      end
      if (capture_event) begin
         next_capture_value = COUNT;
      end
      if (addr_valid) begin
         next_req.write = HWRITE;
         next_req.addr = HADDR;
         next_phase = HWRITE ? tcc_pkg::TCC_PHASE_WRITE : tcc_pkg::TCC_PHASE_READ;
         if (!HWRITE) begin
            if (HADDR == tcc_pkg::OFS_CMP_LO[0]) begin
               next_hrdata[7:0] = cmp[0][7:0];
            end else if (HADDR == tcc_pkg::OFS_CMP_HI[0]) begin
               next_hrdata[7:0] = cmp[0][15:8];
            end else if (HADDR == tcc_pkg::OFS_CMP_LO[1]) begin
               next_hrdata[7:0] = cmp[1][7:0];
            end else if (HADDR == tcc_pkg::OFS_CMP_HI[1]) begin
               next_hrdata[7:0] = cmp[1][15:8];
            end else if (HADDR == tcc_pkg::OFS_CMP_LO[2]) begin
               next_hrdata[7:0] = cmp[2][7:0];
            end else if (HADDR == tcc_pkg::OFS_CMP_HI[2]) begin
               next_hrdata[7:0] = cmp[2][15:8];
            end else if (HADDR == tcc_pkg::OFS_CAP_LO) begin
               next_hrdata[7:0] = capture_value[7:0];
               next_temp = capture_value[15:8];
            end else if (HADDR == tcc_pkg::OFS_CAP_HI) begin
               next_hrdata[7:0] = temp;
            end else if (HADDR == tcc_pkg::OFS_MASK) begin
               next_hrdata[7:0] = mask;
            end else if (HADDR == tcc_pkg::OFS_FLAGS) begin
               next_hrdata[7:0] = flags;
            end else if (HADDR == tcc_pkg::OFS_CTRL) begin
               next_hrdata[tcc_pkg::CTRL_WIDTH-1:0] = ctrl;
            end
         end
      end
   end

   // timer side: a set in the same cycle as a clear keeps the flag
   always_comb begin
      next_blocked = blocked;
      if (COUNT_WRITE) begin
         next_blocked = 1'b1;
      end else if (TIMER_TICK) begin
         next_blocked = 1'b0;
      end
      next_match_pulse = (TIMER_TICK && !blocked) ? equal : 3'h0;
      next_compare_event = match_pulse | force_pulse;
      next_pin_prev = cap_src;
      flag_set = '0;
      flag_set[BIT_A +: 3] = match_pulse;
      flag_set[tcc_pkg::BIT_OVF] = OVERFLOW_EVENT;
      flag_set[tcc_pkg::BIT_CAP] = capture_event || top_reached;
      next_flags = ((flags & ~flag_clr) | flag_set) & tcc_pkg::IRQ_BITS;
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         phase <= tcc_pkg::TCC_PHASE_IDLE;
         req <= '0;
         HRDATA <= tcc_pkg::ZERO32;
         for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
            cmp[i] <= tcc_pkg::RESET16;
         end
         capture_value <= tcc_pkg::RESET16;
         temp <= tcc_pkg::RESET8;
         mask <= tcc_pkg::RESET8;
         flags <= tcc_pkg::RESET8;
         ctrl <= tcc_pkg::CTRL_RESET;
         blocked <= 1'b0;
         match_pulse <= 3'h0;
         force_pulse <= 3'h0;
         COMPARE_EVENT <= 3'h0;
         pin_prev <= 1'b0;
      end else begin
         phase <= next_phase;
         req <= next_req;
         HRDATA <= next_hrdata;
         for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
            cmp[i] <= next_cmp[i];
         end
         capture_value <= next_capture_value;
         temp <= next_temp;
         mask <= next_mask;
         flags <= next_flags;
         ctrl <= next_ctrl;
         blocked <= next_blocked;
         match_pulse <= next_match_pulse;
         force_pulse <= next_force_pulse;
         COMPARE_EVENT <= next_compare_event;
         pin_prev <= next_pin_prev;
      end
   end

   // checks
   a_match_sets_flag: assert property (@(posedge MCLK) disable iff (!NRST)
      TIMER_TICK && !blocked && equal[0] |=> ##1 flags[BIT_A])
      else $error("match A did not set its flag");
   a_match_event: assert property (@(posedge MCLK) disable iff (!NRST)
      match_pulse[1] |=> COMPARE_EVENT[1])
      else $error("match B gave no compare event");
   a_write_blocks_match: assert property (@(posedge MCLK) disable iff (!NRST)
      COUNT_WRITE ##1 (TIMER_TICK && !COUNT_WRITE) |=> match_pulse == 3'h0)
      else $error("match seen on tick after count write");
   a_force_no_flag: assert property (@(posedge MCLK) disable iff (!NRST)
      force_pulse[0] && !match_pulse[0] && !flags[BIT_A] |=> !flags[BIT_A])
      else $error("forced strobe set match flag");
   a_irq_needs_global: assert property (@(posedge MCLK) disable iff (!NRST)
      |IRQ_REQUEST |-> ctrl.global_irq_enable && |(mask & flags))
      else $error("request without enable");
   a_irq_follows: assert property (@(posedge MCLK) disable iff (!NRST)
      ctrl.global_irq_enable && mask[BIT_A] && flags[BIT_A] |->
      IRQ_REQUEST[BIT_A])
      else $error("match A request missing");
   a_mask_reserved: assert property (@(posedge MCLK) disable iff (!NRST)
      addr_valid && !HWRITE && HADDR == tcc_pkg::OFS_MASK |=>
      HRDATA[7:6] == 2'h0 && !HRDATA[4])
      else $error("mask reserved bits read nonzero");
   a_mask_write: assert property (@(posedge MCLK) disable iff (!NRST)
      wr_data && req.addr == tcc_pkg::OFS_MASK |=>
      mask == ($past(HWDATA[7:0]) & tcc_pkg::IRQ_BITS))
      else $error("mask write kept a reserved bit");
   // flag and copy land on the same edge, so both are seen one cycle on
   a_capture_copy: assert property (@(posedge MCLK) disable iff (!NRST)
      capture_event |=> capture_value == $past(COUNT) && flags[tcc_pkg::BIT_CAP])
      else $error("capture did not copy count");
   a_capture_latch: assert property (@(posedge MCLK) disable iff (!NRST)
      addr_valid && !HWRITE && HADDR == tcc_pkg::OFS_CAP_LO |=>
      temp == $past(capture_value[15:8]))
      else $error("capture low read did not fill latch");
   a_capture_off_top: assert property (@(posedge MCLK) disable iff (!NRST)
      CAPTURE_IS_TOP |-> !capture_event)
      else $error("capture while capture is top");
   a_top_flag: assert property (@(posedge MCLK) disable iff (!NRST)
      top_reached |=> flags[tcc_pkg::BIT_CAP])
      else $error("top reached without capture flag");
   a_overflow_sets: assert property (@(posedge MCLK) disable iff (!NRST)
      OVERFLOW_EVENT |=> flags[tcc_pkg::BIT_OVF])
      else $error("overflow did not set its flag");
   a_flags_reserved: assert property (@(posedge MCLK) disable iff (!NRST)
      (flags & ~tcc_pkg::IRQ_BITS) == tcc_pkg::RESET8)
      else $error("reserved flag bit set");
   a_w1c_clear: assert property (@(posedge MCLK) disable iff (!NRST)
      wr_data && req.addr == tcc_pkg::OFS_FLAGS && HWDATA[tcc_pkg::BIT_OVF] && !OVERFLOW_EVENT
      |=> !flags[tcc_pkg::BIT_OVF])
      else $error("write one did not clear overflow flag");
   a_set_beats_clear: assert property (@(posedge MCLK) disable iff (!NRST)
      VECTOR_ACK[tcc_pkg::BIT_OVF] && OVERFLOW_EVENT |=> flags[tcc_pkg::BIT_OVF])
      else $error("clear won over set");
   a_vector_clear: assert property (@(posedge MCLK) disable iff (!NRST)
      VECTOR_ACK[tcc_pkg::BIT_OVF] && !OVERFLOW_EVENT && !wr_data
      |=> !flags[tcc_pkg::BIT_OVF])
      else $error("vector did not clear flag");
   a_atomic_write: assert property (@(posedge MCLK) disable iff (!NRST)
      wr_data && req.addr == tcc_pkg::OFS_CMP_LO[0] |=>
      cmp[0] == {$past(temp), $past(HWDATA[7:0])})
      else $error("compare A not written as one word");

   c_capture: cover property (@(posedge MCLK) disable iff (!NRST) capture_event);
   c_top: cover property (@(posedge MCLK) disable iff (!NRST) top_reached);
   c_match_flag: cover property (@(posedge MCLK) disable iff (!NRST) $rose(flags[BIT_A]));
   c_irq: cover property (@(posedge MCLK) disable iff (!NRST) |IRQ_REQUEST);
   c_blocked_tick: cover property (@(posedge MCLK) disable iff (!NRST) blocked && TIMER_TICK);
endmodule

// File: verification/tcc_counter_model.sv
`timescale 1ns/1ps
module tcc_counter_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_value,
   output logic [15:0] count,
   output logic tick,
   output logic overflow,
   output logic count_write
);
   // count holds while stopped, so the bench knows what a capture will see
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
         tick <= 1'b0;
         overflow <= 1'b0;
         count_write <= 1'b0;
      end else begin
         tick <= run & ~tick;
         count_write <= load;
         overflow <= tick && (count == 16'hffff);
         if (load) begin
            count <= load_value;
         end else if (tick) begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [3:0] wave_mode = 4'h0;
   logic cap_pin = 1'b0;
   logic [7:0] vec_ack = 8'h00;
   logic comp_out = 1'b0;
   logic run = 1'b0;
   logic load = 1'b0;
   logic [15:0] load_value = 16'h0000;
   logic hready, hresp, tick, count_write, overflow, is_top;
   logic [31:0] hrdata, rd;
   logic [15:0] count, top_value;
   logic [2:0] cmp_evt;
   logic [7:0] irq;
   int err_count = 0;
   int compares = 0;
   int evt_seen = 0;
   int e0;

   always #2.5 mclk = ~mclk;
   always @(posedge mclk) evt_seen <= evt_seen + $countones(cmp_evt);

   tcc_compare_capture tcc_compare_capture_inst (.MCLK(mclk), .NRST(nrst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .COUNT(count),
      .TIMER_TICK(tick), .COUNT_WRITE(count_write), .OVERFLOW_EVENT(overflow),
      .WAVE_MODE(wave_mode), .CAPTURE_PIN(cap_pin), .COMPARATOR_OUT(comp_out),
      .VECTOR_ACK(vec_ack), .COMPARE_EVENT(cmp_evt), .IRQ_REQUEST(irq),
      .CAPTURE_TOP_VALUE(top_value), .CAPTURE_IS_TOP(is_top));
   tcc_counter_model tcc_counter_model_inst (.clk(mclk), .rst_n(nrst), .run(run),
      .load(load), .load_value(load_value), .count(count), .tick(tick),
      .overflow(overflow), .count_write(count_write));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single transfer; waits on hready, read data taken at the data-phase edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= tcc_pkg::HTRANS_NONSEQ;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(what, rd, exp);
   endtask

   task automatic flags_is(input logic [7:0] e);
      rd_chk("flags", tcc_pkg::OFS_FLAGS, {24'h000000, e});
   endtask

   task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
      bus(1'b1, hi, {24'h000000, v[15:8]});
      bus(1'b1, lo, {24'h000000, v[7:0]});
   endtask

   task automatic load_count(input logic [15:0] v);
      load <= 1'b1;
      load_value <= v;
      @(posedge mclk);
      load <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic run_for(input int n);
      run <= 1'b1;
      repeat (n) @(posedge mclk);
      run <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic pin_to(input logic v);
      cap_pin <= v;
      repeat (8) @(posedge mclk);
   endtask

   task automatic test_reset;
      for (int a = 0; a <= 48; a += 4) rd_chk("reset word", 8'(a), 32'h0);
      bus(1'b1, tcc_pkg::OFS_MASK, 32'h000000ff);
      rd_chk("mask", tcc_pkg::OFS_MASK, 32'h0000002f);
      bus(1'b1, 8'h30, 32'h000000ff);
      rd_chk("unmapped", 8'h30, 32'h0);
      $display("test reset done");
   endtask

   task automatic test_compare;
      bus(1'b1, tcc_pkg::OFS_CMP_HI[0], 32'h00000001);
      rd_chk("hi alone", tcc_pkg::OFS_CMP_HI[0], 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr16(tcc_pkg::OFS_CMP_LO[i], tcc_pkg::OFS_CMP_HI[i], 16'(16'h0103 + 2 * i));
         rd_chk("cmp lo", tcc_pkg::OFS_CMP_LO[i], 32'(8'h03 + 2 * i));
         rd_chk("cmp hi", tcc_pkg::OFS_CMP_HI[i], 32'h01);
      end
      load_count(16'h0100);
      e0 = evt_seen;
      run_for(20);
      flags_is(8'h0e);
      check("match pulses", 32'(evt_seen - e0), 32'd3);
      check("irq global off", {24'h0, irq}, 32'h0);
      // a write lands on the data-phase edge, so the request is looked at one edge on
      bus(1'b1, tcc_pkg::OFS_CTRL, 32'h8);
      @(posedge mclk);
      check("irq on", {24'h0, irq}, 32'h0e);
      bus(1'b1, tcc_pkg::OFS_MASK, 32'h2);
      @(posedge mclk);
      check("irq masked", {24'h0, irq}, 32'h02);
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h0);
      flags_is(8'h0e);
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2);
      flags_is(8'h0c);
      vec_ack <= 8'h04;
      @(posedge mclk);
      vec_ack <= 8'h00;
      flags_is(8'h08);
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2f);
      // a count write hides the match on the first tick, later ones still count
      load_count(16'h0103);
      run_for(6);
      flags_is(8'h04);
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2f);
      load_count(16'hfffe);
      run_for(6);
      flags_is(8'h01);
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2f);
      e0 = evt_seen;
      bus(1'b1, tcc_pkg::OFS_FORCE, 32'h7);
      repeat (4) @(posedge mclk);
      check("forced pulses", 32'(evt_seen - e0), 32'd3);
      flags_is(8'h00);
      rd_chk("force reads", tcc_pkg::OFS_FORCE, 32'h0);
      $display("test compare done");
   endtask

   task automatic test_capture;
      bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0);
      load_count(16'h1234);
      pin_to(1'b1);
      flags_is(8'h00);
      pin_to(1'b0);
      flags_is(8'h20);
      rd_chk("cap lo", tcc_pkg::OFS_CAP_LO, 32'h34);
      load_count(16'h5678);
      bus(1'b1, tcc_pkg::OFS_CTRL, 32'h1);
      pin_to(1'b1);
      rd_chk("cap hi held", tcc_pkg::OFS_CAP_HI, 32'h12);
      rd_chk("cap lo", tcc_pkg::OFS_CAP_LO, 32'h78);
      rd_chk("cap hi", tcc_pkg::OFS_CAP_HI, 32'h56);
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2f);
      bus(1'b1, tcc_pkg::OFS_CTRL, 32'h3);
      pin_to(1'b0);
      cap_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      pin_to(1'b0);
      flags_is(8'h00);
      pin_to(1'b1);
      flags_is(8'h20);
      // comparator source: let the low level register first, then raise it
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2f);
      load_count(16'h4321);
      bus(1'b1, tcc_pkg::OFS_CTRL, 32'h5);
      repeat (2) @(posedge mclk);
      comp_out <= 1'b1;
      repeat (4) @(posedge mclk);
      flags_is(8'h20);
      rd_chk("comparator lo", tcc_pkg::OFS_CAP_LO, 32'h21);
      rd_chk("comparator hi", tcc_pkg::OFS_CAP_HI, 32'h43);
      $display("test capture done");
   endtask

   task automatic test_top;
      bus(1'b1, tcc_pkg::OFS_FLAGS, 32'h2f);
      bus(1'b1, tcc_pkg::OFS_CTRL, 32'h1);
      wave_mode <= tcc_pkg::MODE_CTC_CAP;
      wr16(tcc_pkg::OFS_CAP_LO, tcc_pkg::OFS_CAP_HI, 16'h0010);
      @(posedge mclk);
      check("is top", {31'h0, is_top}, 32'h1);
      check("top value", {16'h0, top_value}, 32'h10);
      pin_to(1'b0);
      pin_to(1'b1);
      rd_chk("cap kept", tcc_pkg::OFS_CAP_LO, 32'h10);
      flags_is(8'h00);
      load_count(16'h000e);
      run_for(6);
      flags_is(8'h20);
      wave_mode <= tcc_pkg::MODE_PFC_CAP;
      e0 = evt_seen;
      bus(1'b1, tcc_pkg::OFS_FORCE, 32'h7);
      repeat (4) @(posedge mclk);
      check("pwm force", 32'(evt_seen - e0), 32'd0);
      check("top mode 8", {31'h0, is_top}, 32'h1);
      wave_mode <= tcc_pkg::MODE_PC_CAP;
      @(posedge mclk);
      check("top mode 10", {31'h0, is_top}, 32'h1);
      wave_mode <= tcc_pkg::MODE_FAST_CAP;
      @(posedge mclk);
      check("top mode 14", {31'h0, is_top}, 32'h1);
      wave_mode <= tcc_pkg::MODE_NORMAL;
      @(posedge mclk);
      check("not top", {31'h0, is_top}, 32'h0);
      $display("test top done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      test_reset();
      test_compare();
      test_capture();
      test_top();
      wrap_up();
   end
endmodule
